// File: hdl/pllbc_pkg.sv
// package: register map, field layout and reset values of the pll programming block
package pllbc_pkg;
  // register indices (byte addresses on the plain port)
  localparam logic [2:0] ADDR_CONTROL    = 3'h0;
  localparam logic [2:0] ADDR_MULT_HIGH  = 3'h2;
  localparam logic [2:0] ADDR_MULT_LOW   = 3'h3;
  localparam logic [2:0] ADDR_RANGE_SEL  = 3'h4;
  localparam logic [2:0] ADDR_STATUS     = 3'h5;
  // control register fields
  localparam int POS_PLL_ON   = 5;
  localparam int POS_BASE_SEL = 4;
  localparam int POS_VPR_HI   = 1;
  localparam int POS_VPR_LO   = 0;
  // reset values
  localparam logic       RST_PLL_ON     = 1'b1;
  localparam logic       RST_BASE_SEL   = 1'b0;
  localparam logic [1:0] RST_VPR        = 2'h0;
  localparam logic [3:0] RST_MULT_HIGH  = 4'h0;
  localparam logic [7:0] RST_MULT_LOW   = 8'h40;
  localparam logic [7:0] RST_RANGE_SEL  = 8'h40;
  // transition wait, in cycles of each source clock
  localparam int SWITCH_WAIT = 3;
  localparam logic [1:0] SWITCH_WAIT_M1 = 2'h2;

  typedef struct packed {
    logic       pll_power_on;
    logic       base_clock_select;
    logic [1:0] vco_power_range;
    logic [11:0] range_mult;
    logic [7:0] linear_mult;
  } pllbc_prog_t;
endpackage

// File: hdl/pllbc_top.sv
// pll programming registers and base clock selector with glitch-free switch
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - bus clock is a quarter of the selected clock: base halves, bus halves again.
// - chosen clock divided by two after transition, giving balanced base clock.
// - source change waits three clocks of each source; base clock held static.
// - base clock select bit in control register picks crystal or vco.
// - select one drives vco halved; zero drives crystal halved.
// - setting select is refused while pll power on is clear.
// - clearing power on is ignored while vco is selected.
// - power on and select cannot both change in one write.
// - linear multiplier zero disables pll and forces crystal source.
// - range multiplier zero acts as one in the feedback divider.
// - programming registers ignore writes while pll power on is set.
module pllbc_top
  import pllbc_pkg::*;
(
  // system clock and register port
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  input  wire logic [2:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  output logic      [7:0]  rdata_out,
  // source clocks, asynchronous to sys_clk_in
  input  wire logic        crystal_clock_in,
  input  wire logic        vco_clock_in,
  // clock outputs and programming state
  output logic             base_clock_out,
  output logic             bus_clock_out,
  output logic             pll_enable_out,
  output logic      [11:0] feedback_div_out,
  output logic      [7:0]  linear_mult_out,
  output logic      [1:0]  vco_power_range_out
);
  pllbc_prog_t prog;
  pllbc_prog_t next_prog;
  logic [7:0]  next_rdata;
  logic        l_zero;

  assign l_zero = (prog.linear_mult == 8'h00);

  // programming fields are frozen while the loop runs, so a retune needs power off first
  function automatic logic prog_writable(input pllbc_prog_t p);
    return !p.pll_power_on;
  endfunction

  always_comb begin
    next_prog = prog;
    if (write_in) begin
      unique case (addr_in)
        ADDR_CONTROL: begin
          // power on and select may not move together; the later is rejected
          if (wdata_in[POS_PLL_ON] != prog.pll_power_on) begin
            if (wdata_in[POS_PLL_ON] || !prog.base_clock_select) begin
              next_prog.pll_power_on = wdata_in[POS_PLL_ON];
            end
          end else if (wdata_in[POS_BASE_SEL] && prog.pll_power_on && !l_zero) begin
            next_prog.base_clock_select = 1'b1;
          end else if (!wdata_in[POS_BASE_SEL]) begin
            next_prog.base_clock_select = 1'b0;
          end
          if (prog_writable(prog)) begin
            next_prog.vco_power_range = wdata_in[POS_VPR_HI:POS_VPR_LO];
          end
        end
        ADDR_MULT_HIGH: begin
          if (prog_writable(prog)) begin
            next_prog.range_mult[11:8] = wdata_in[3:0];
          end
        end
        ADDR_MULT_LOW: begin
          if (prog_writable(prog)) begin
            next_prog.range_mult[7:0] = wdata_in;
          end
        end
        ADDR_RANGE_SEL: begin
          if (prog_writable(prog)) begin
            next_prog.linear_mult = wdata_in;
          end
        end
        default: begin
        end
      endcase
    end
    if (l_zero) begin
      next_prog.base_clock_select = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      prog.pll_power_on      <= RST_PLL_ON;
      prog.base_clock_select <= RST_BASE_SEL;
      prog.vco_power_range   <= RST_VPR;
      prog.range_mult        <= {RST_MULT_HIGH, RST_MULT_LOW};
      prog.linear_mult       <= RST_RANGE_SEL;
    end else begin
      prog <= next_prog;
    end
  end

  // system-side outputs and readback
  logic        vco_active;
  logic        cur_src_sync1;
  logic        cur_src_sync2;
  logic        next_pll_enable;
  logic [11:0] next_fb_div;

  always_comb begin
    next_rdata = 8'h00;
    if (read_in) begin
      unique case (addr_in)
        ADDR_CONTROL:   next_rdata = {2'b00, prog.pll_power_on, prog.base_clock_select, 2'b00, prog.vco_power_range};
        ADDR_MULT_HIGH: next_rdata = {4'h0, prog.range_mult[11:8]};
        ADDR_MULT_LOW:  next_rdata = prog.range_mult[7:0];
        ADDR_RANGE_SEL: next_rdata = prog.linear_mult;
        ADDR_STATUS:    next_rdata = {7'h00, cur_src_sync2};
        default:        next_rdata = 8'h00;
      endcase
    end
    next_pll_enable = prog.pll_power_on && !l_zero;
    next_fb_div = (prog.range_mult == 12'h000) ? 12'h001 : prog.range_mult;
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_out           <= 8'h00;
      pll_enable_out      <= 1'b0;
      feedback_div_out    <= 12'h001;
      linear_mult_out     <= 8'h00;
      vco_power_range_out <= 2'h0;
      cur_src_sync1       <= 1'b0;
      cur_src_sync2       <= 1'b0;
    end else begin
      rdata_out           <= next_rdata;
      pll_enable_out      <= next_pll_enable;
      feedback_div_out    <= next_fb_div;
      linear_mult_out     <= prog.linear_mult;
      vco_power_range_out <= prog.vco_power_range;
      cur_src_sync1       <= vco_active;
      cur_src_sync2       <= cur_src_sync1;
    end
  end

  // glitch-free switch: each source gates on only after the other releases;
  // the select and the hand-off flag are synchronised per domain so no clock
  // is cut mid-pulse. reset is caught in each domain through the same pair.
  logic xs1, xs2, xo1, xo2, xrst1, xrst2;
  logic vs1, vs2, vo1, vo2, vrst1, vrst2;
  logic [1:0] xcnt, next_xcnt;
  logic [1:0] vcnt, next_vcnt;
  logic xgate, next_xgate, vgate, next_vgate;

  // per-domain reset hold: a source clock may be far slower than the system
  // clock, so each domain keeps its reset until it reports having seen it
  logic xhold;
  logic next_xhold;
  logic vhold;
  logic next_vhold;
  logic xack1;
  logic xack2;
  logic vack1;
  logic vack2;

  always_comb begin
    next_xhold = xhold;
    next_vhold = vhold;
    if (xack2) begin
      next_xhold = 1'b0;
    end
    if (vack2) begin
      next_vhold = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      xhold <= 1'b1;
      vhold <= 1'b1;
      xack1 <= 1'b0;
      xack2 <= 1'b0;
      vack1 <= 1'b0;
      vack2 <= 1'b0;
    end else begin
      xhold <= next_xhold;
      vhold <= next_vhold;
      xack1 <= xrst2;
      xack2 <= xack1;
      vack1 <= vrst2;
      vack2 <= vack1;
    end
  end

  // crystal domain: enabled while select low and vco gate confirmed off
  always_comb begin
    next_xcnt  = xcnt;
    next_xgate = xgate;
    if (xs2 || xo2) begin
      next_xgate = 1'b0;
      next_xcnt  = 2'h0;
    end else if (xcnt != SWITCH_WAIT_M1) begin
      next_xcnt = xcnt + 2'h1;
    end else begin
      next_xgate = 1'b1;
    end
  end

  always_ff @(negedge crystal_clock_in) begin
    xrst1 <= xhold;
    xrst2 <= xrst1;
    xs1   <= prog.base_clock_select;
    xs2   <= xs1;
    xo1   <= vgate;
    xo2   <= xo1;
    if (xrst2) begin
      xcnt  <= 2'h0;
      xgate <= 1'b0;
    end else begin
      xcnt  <= next_xcnt;
      xgate <= next_xgate;
    end
  end

  // vco domain: enabled while select high and crystal gate confirmed off
  always_comb begin
    next_vcnt  = vcnt;
    next_vgate = vgate;
    if (!vs2 || vo2) begin
      next_vgate = 1'b0;
      next_vcnt  = 2'h0;
    end else if (vcnt != SWITCH_WAIT_M1) begin
      next_vcnt = vcnt + 2'h1;
    end else begin
      next_vgate = 1'b1;
    end
  end

  always_ff @(negedge vco_clock_in) begin
    vrst1 <= vhold;
    vrst2 <= vrst1;
    vs1   <= prog.base_clock_select;
    vs2   <= vs1;
    vo1   <= xgate;
    vo2   <= vo1;
    if (vrst2) begin
      vcnt  <= 2'h0;
      vgate <= 1'b0;
    end else begin
      vcnt  <= next_vcnt;
      vgate <= next_vgate;
    end
  end

  assign vco_active = vgate;

  // gates change on falling edges, so the muxed clock never carries a runt
  logic sel_clock;
  assign sel_clock = (crystal_clock_in & xgate) | (vco_clock_in & vgate);

  // divide by two for duty cycle, then by two again for the bus clock; both
  // clear on the crystal-side reset, while every gate holds the muxed clock low
  logic base_div;
  logic next_base_div;
  logic bus_div;
  logic next_bus_div;

  always_comb begin
    next_base_div = ~base_div;
    next_bus_div  = ~bus_div;
  end

  always_ff @(posedge sel_clock or posedge xrst2) begin
    if (xrst2) begin
      base_div <= 1'b0;
    end else begin
      base_div <= next_base_div;
    end
  end

  // ripple stage: a quarter-rate clock needs no edge of its own source
  always_ff @(posedge base_div or posedge xrst2) begin
    if (xrst2) begin
      bus_div <= 1'b0;
    end else begin
      bus_div <= next_bus_div;
    end
  end

  always_comb begin
    base_clock_out = base_div;
    bus_clock_out  = bus_div;
  end
endmodule

`default_nettype wire

// File: sim/pllbc_monitor.sv
// port-level checker of the pll programming and base clock select block
`timescale 1ns/10ps
`default_nettype none
module pllbc_monitor
  import pllbc_pkg::*;
(
  // system side
  input wire logic        sys_clk_in,
  input wire logic        reset_in,
  input wire logic [2:0]  addr_in,
  input wire logic        write_in,
  // clock and programming outputs
  input wire logic        base_clock_out,
  input wire logic        bus_clock_out,
  input wire logic        pll_enable_out,
  input wire logic [11:0] feedback_div_out,
  input wire logic [7:0]  linear_mult_out,
  input wire logic [1:0]  vco_power_range_out
);
  // dividers reset only through the crystal-side reset, not reset_in, so skip the first base edge
  logic seen_base;
  always_ff @(posedge base_clock_out) begin
    seen_base <= 1'b1;
  end
  // write taken while power on held the registers
  sequence s_locked_wr(a);
    write_in && addr_in == a ##1 pll_enable_out;
  endsequence
  property p_div_nz; @(posedge sys_clk_in) disable iff (reset_in) feedback_div_out != 12'h000; endproperty
  a_div_nz: assert property (p_div_nz) else $error("divider reads zero");
  property p_l_zero; @(posedge sys_clk_in) disable iff (reset_in) linear_mult_out == 8'h00 |-> !pll_enable_out; endproperty
  a_l_zero: assert property (p_l_zero) else $error("pll on with zero multiplier");
  property p_lk_lo; @(posedge sys_clk_in) disable iff (reset_in) s_locked_wr(ADDR_MULT_LOW) |=> $stable(feedback_div_out); endproperty
  a_lk_lo: assert property (p_lk_lo) else $error("low multiplier written while on");
  property p_lk_hi; @(posedge sys_clk_in) disable iff (reset_in) s_locked_wr(ADDR_MULT_HIGH) |=> $stable(feedback_div_out); endproperty
  a_lk_hi: assert property (p_lk_hi) else $error("high multiplier written while on");
  property p_lk_l; @(posedge sys_clk_in) disable iff (reset_in) s_locked_wr(ADDR_RANGE_SEL) |=> $stable(linear_mult_out); endproperty
  a_lk_l: assert property (p_lk_l) else $error("linear multiplier written while on");
  property p_lk_e; @(posedge sys_clk_in) disable iff (reset_in) s_locked_wr(ADDR_CONTROL) |=> $stable(vco_power_range_out); endproperty
  a_lk_e: assert property (p_lk_e) else $error("exponent written while on");
  property p_bus_q; @(posedge base_clock_out) disable iff (reset_in) seen_base |-> bus_clock_out != $past(bus_clock_out); endproperty
  a_bus_q: assert property (p_bus_q) else $error("bus clock not half of base");
  property p_no_runt; @(posedge sys_clk_in) disable iff (reset_in) $changed(base_clock_out) |=> $stable(base_clock_out); endproperty
  a_no_runt: assert property (p_no_runt) else $error("runt on base clock");
endmodule
bind pllbc_top pllbc_monitor u_mon (.sys_clk_in, .reset_in, .addr_in, .write_in, .base_clock_out, .bus_clock_out,
  .pll_enable_out, .feedback_div_out, .linear_mult_out, .vco_power_range_out);
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the pll programming and base clock select block
`timescale 1ns/10ps
`default_nettype none
module tb_top import pllbc_pkg::*;;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, write_in = 1'b0, read_in = 1'b0;
  logic crystal_clock_in = 1'b0, vco_clock_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, linear_mult_out, rv;
  logic base_clock_out, bus_clock_out, pll_enable_out;
  logic [11:0] feedback_div_out;
  logic [1:0] vco_power_range_out;
  int error_cnt = 0, n_checks = 0, nb = 0, nu = 0;
  pllbc_top dut (.sys_clk_in, .reset_in, .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
    .crystal_clock_in, .vco_clock_in, .base_clock_out, .bus_clock_out, .pll_enable_out,
    .feedback_div_out, .linear_mult_out, .vco_power_range_out);
  initial forever #10 sys_clk_in = ~sys_clk_in;
  // odd offsets keep source edges off the system edges
  initial begin
    #3;
    forever #40 crystal_clock_in = ~crystal_clock_in;
  end
  initial begin
    #7;
    forever #20 vco_clock_in = ~vco_clock_in;
  end
  always @(posedge base_clock_out) nb++;
  always @(posedge bus_clock_out) nu++;
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) fail("value mismatch");
  endtask
  task automatic near(input int got, input int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1) fail("clock edge count");
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge sys_clk_in);
    write_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge sys_clk_in);
    read_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk(12'(rv), 12'(e));
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  // status bit0 follows the clock actually driving the output
  task automatic wait_src(input logic e);
    rd(ADDR_STATUS);
    for (int i = 0; i < 100 && rv[0] !== e; i++) rd(ADDR_STATUS);
    chk(12'(rv[0]), 12'(e));
    if (rv[0] !== e) final_report();
  endtask
  // lead-in lets the gate hand-off finish, then a 5120 ns window of base edges
  task automatic meas(input int eb);
    #640;
    nb = 0;
    nu = 0;
    #5120;
    near(nb, eb);
    near(nu, eb / 2);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    settle();
    rc(ADDR_CONTROL, 8'h20);
    rc(ADDR_MULT_HIGH, 8'h00);
    rc(ADDR_MULT_LOW, 8'h40);
    rc(ADDR_RANGE_SEL, 8'h40);
    rc(3'h1, 8'h00);
    chk(feedback_div_out, 12'h040);
    meas(32);
    wr(ADDR_MULT_LOW, 8'h00);
    wr(ADDR_MULT_HIGH, 8'h0F);
    wr(ADDR_RANGE_SEL, 8'h00);
    wr(ADDR_CONTROL, 8'h22);
    rc(ADDR_MULT_LOW, 8'h40);
    rc(ADDR_MULT_HIGH, 8'h00);
    rc(ADDR_CONTROL, 8'h20);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MULT_LOW, 8'h00);
    wr(ADDR_RANGE_SEL, 8'h00);
    wr(ADDR_CONTROL, 8'h02);
    settle();
    chk(feedback_div_out, 12'h001);
    chk(12'(vco_power_range_out), 12'h002);
    wr(ADDR_CONTROL, 8'h32);
    rc(ADDR_CONTROL, 8'h22);
    settle();
    chk(12'(pll_enable_out), 12'h000);
    wr(ADDR_CONTROL, 8'h32);
    rc(ADDR_CONTROL, 8'h22);
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_RANGE_SEL, 8'h45);
    wr(ADDR_CONTROL, 8'h12);
    rc(ADDR_CONTROL, 8'h02);
    wr(ADDR_CONTROL, 8'h22);
    wr(ADDR_CONTROL, 8'h32);
    rc(ADDR_CONTROL, 8'h32);
    wr(ADDR_CONTROL, 8'h12);
    rc(ADDR_CONTROL, 8'h32);
    wait_src(1'b1);
    chk(12'(linear_mult_out), 12'h045);
    chk(12'(pll_enable_out), 12'h001);
    meas(64);
    wr(ADDR_CONTROL, 8'h22);
    rc(ADDR_CONTROL, 8'h22);
    wait_src(1'b0);
    meas(32);
    final_report();
  end
endmodule
`default_nettype wire
